// ---- logic/pdc_pkg.sv ----
`default_nettype none
// ****************************************************************
// Shared constants of the power-down control block.
// ****************************************************************
package pdc_pkg;
	// Command-decode delay after the CKE fall at entry, in CK cycles.
	localparam int unsigned T_CPDED_NCK   = 4;
	// Least CKE hold time after entry or exit, in CK cycles.
	localparam int unsigned T_CKE_NCK     = 6;
	// Power-down exit latency to a valid command, in CK cycles.
	localparam int unsigned T_XP_NCK      = 8;
	// Refresh interval, in CK cycles.
	localparam int unsigned T_REFI_NCK    = 6240;
	// Number of refresh intervals that bound one power-down period.
	localparam int unsigned PD_REFI_LIMIT = 9;
	// Largest write latency that the entry window logic serves.
	localparam int unsigned WL_MAX        = 32;
	// Width of the short timers.
	localparam int unsigned SHORT_W       = 8;

	// Controller states, one-hot.
	typedef enum logic [4:0] {
		PDC_RESET = 5'h01,
		PDC_IDLE  = 5'h02,
		PDC_ENTRY = 5'h04,
		PDC_DOWN  = 5'h08,
		PDC_EXIT  = 5'h10
	} pdc_state_t;
endpackage
`default_nettype wire

// ---- logic/pdc_tmr_if.sv ----
`default_nettype none
// ****************************************************************
// Carrier between the controller and one of its cycle timers.
// ****************************************************************
interface pdc_tmr_if #(
	parameter int unsigned W = 8
);
	logic         load;  // Loads the start value.
	logic         tick;  // One CK edge has passed.
	logic [W-1:0] value; // Start value of the count.
	logic         done;  // Count has run out.

	modport owner (output load, output tick, output value, input done);
	modport timer (input load, input tick, input value, output done);
endinterface
`default_nettype wire

// ---- logic/pdc_timer.sv ----
`default_nettype none
// ****************************************************************
// Down counter that runs on CK edge ticks.
// ****************************************************************
module pdc_timer #(
	parameter int unsigned W = 8
) (
	input  wire logic clk,   // System clock.
	input  wire logic rst,   // Asynchronous reset, active high.
	pdc_tmr_if.timer  t      // Load, tick and done.
);
	logic [W-1:0] cnt; // Remaining ticks.

	// A load restarts the count; ticks only count down while above zero.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
		end else if (t.load) begin
			cnt <= t.value;
		end else if (t.tick && (cnt != '0)) begin
			cnt <= cnt - 1'b1;
		end
	end

	// Done stands from the tick that empties the count until a load refills it.
	// It shows the count as it stands, so a check made in the loading cycle still
	// judges the run that the load ends.
	assign t.done = (cnt == '0);
endmodule // pdc_timer
`default_nettype wire

// ---- logic/pdc_top.sv ----
`default_nettype none
module pdc_top #(
	parameter int unsigned CPDED_NCK = pdc_pkg::T_CPDED_NCK,                // Entry delay.
	parameter int unsigned CKE_NCK   = pdc_pkg::T_CKE_NCK,                  // CKE hold.
	parameter int unsigned XP_NCK    = pdc_pkg::T_XP_NCK,                   // Exit latency.
	parameter int unsigned PD_MAX_NCK = pdc_pkg::PD_REFI_LIMIT * pdc_pkg::T_REFI_NCK, // Limit.
	parameter int unsigned WLMAX     = pdc_pkg::WL_MAX                      // Largest WL.
) (
	input  wire logic                     clk,               // System clock, 50 MHz.
	input  wire logic                     rst,               // Asynchronous reset, high.
	input  wire logic                     ck_pin,            // Memory clock from controller.
	input  wire logic                     cke_pin,           // Clock enable pin.
	input  wire logic                     cs_n_pin,          // Chip select, high is deselect.
	input  wire logic                     reset_n_pin,       // Device reset pin, low active.
	input  wire logic                     odt_pin,           // Termination control pin.
	input  wire logic                     banks_open,        // At least one bank is open.
	input  wire logic                     core_busy,         // Activate, precharge, refresh run.
	input  wire logic                     locked_op_busy,    // MRS, MPR, ZQ, DLL lock, burst run.
	input  wire logic                     dll_locked,        // DLL is locked.
	input  wire logic                     dll_reset_done,    // DLL reset has been performed.
	input  wire logic                     odt_ibuf_off_mode, // ODT buffer disable mode bit.
	input  wire logic [2:0]               park_sel,          // Park termination field.
	input  wire logic                     nom_term_cfg,      // Nominal termination configured.
	input  wire logic [$clog2(WLMAX+1)-1:0] write_lat,       // Write latency in CK cycles.
	output logic                          in_reset,          // Device is in its reset state.
	output logic                          pd_state,          // Device is powered down.
	output logic                          pd_precharge,      // Precharge power-down mode.
	output logic                          pd_active,         // Active power-down mode.
	output logic                          pd_low_current,    // Power-down current applies.
	output logic                          io_buf_en,         // Data and other input buffers on.
	output logic                          cmd_rx_en,         // Command and address receivers on.
	output logic                          odt_buf_en,        // ODT input buffer on.
	output logic                          nom_term_en,       // Nominal termination provided.
	output logic                          park_term_en,      // Park termination provided.
	output logic                          dll_en,            // DLL enabled.
	output logic                          cmd_ready,         // Valid commands may follow.
	output logic                          dll_reset_req,     // DLL reset needed before reads.
	output logic                          anpd_odt,          // ODT seen in the entry window.
	output logic                          err_cke_forbidden, // CKE fell during a locked op.
	output logic                          err_cke_hold,      // CKE toggled inside tCKE.
	output logic                          err_pd_duration    // Power-down ran past its limit.
);
	localparam int unsigned WLW = $clog2(WLMAX + 1);       // Width of the write latency.
	localparam int unsigned DW  = $clog2(PD_MAX_NCK + 1);  // Width of the duration timer.
	localparam int unsigned SW  = pdc_pkg::SHORT_W;        // Width of the short timers.

	// ****************************************************************
	// Elaboration checks.
	// ****************************************************************
	if ((CPDED_NCK < 1) || (CPDED_NCK >= (1 << SW)) || (CKE_NCK < 1) ||
	    (CKE_NCK >= (1 << SW)) || (XP_NCK < 1) || (XP_NCK >= (1 << SW)) ||
	    (PD_MAX_NCK < 1) || (WLMAX < 2)) begin : g_bad_cfg
		$error("pdc_top: timing parameter out of range");
	end

	// ****************************************************************
	// Pin synchronisers and CK edge detection.
	// ****************************************************************
	logic [4:0] pin_s1;   // First stage, read only by the second stage.
	logic [4:0] pin_s2;   // Second stage, safe to use.
	logic       ck_prev;  // CK level one cycle earlier.
	logic       ck_edge;  // One-cycle pulse on each rising CK edge.
	logic       cke_s;    // Synchronised CKE.
	logic       desel_s;  // Synchronised deselect.
	logic       rstn_s;   // Synchronised reset pin.
	logic       odt_s;    // Synchronised ODT.

	// All pins pass two flops; the reset pin resets low so the device starts in reset.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_s1  <= 5'h00;
			pin_s2  <= 5'h00;
			ck_prev <= 1'b0;
		end else begin
			pin_s1  <= {odt_pin, reset_n_pin, cs_n_pin, cke_pin, ck_pin};
			pin_s2  <= pin_s1;
			ck_prev <= pin_s2[0];
		end
	end

	assign ck_edge = pin_s2[0] && !ck_prev;
	assign cke_s   = pin_s2[1];
	assign desel_s = pin_s2[2];
	assign rstn_s  = pin_s2[3];
	assign odt_s   = pin_s2[4];

	// ****************************************************************
	// Cycle timers.
	// ****************************************************************
	pdc_tmr_if #(.W(SW)) seq_t ();   // tCPDED after entry, tXP after exit.
	pdc_tmr_if #(.W(SW)) hold_t ();  // tCKE hold after each transition.
	pdc_tmr_if #(.W(DW)) dur_t ();   // Length of one power-down period.

	pdc_timer #(.W(SW)) u_seq  (.clk(clk), .rst(rst), .t(seq_t));
	pdc_timer #(.W(SW)) u_hold (.clk(clk), .rst(rst), .t(hold_t));
	pdc_timer #(.W(DW)) u_dur  (.clk(clk), .rst(rst), .t(dur_t));

	pdc_pkg::pdc_state_t state;       // Present state.
	pdc_pkg::pdc_state_t next_state;  // State after this cycle.
	logic                enter_now;   // Entry registered on this edge.
	logic                exit_now;    // Exit registered on this edge.

	assign enter_now = ck_edge && !cke_s && desel_s && (state == pdc_pkg::PDC_IDLE);
	assign exit_now  = ck_edge && cke_s && desel_s &&
	                   ((state == pdc_pkg::PDC_ENTRY) || (state == pdc_pkg::PDC_DOWN));

	// Timer loads follow the transitions; all timers count CK edges only.
	assign seq_t.tick   = ck_edge;
	assign hold_t.tick  = ck_edge;
	assign dur_t.tick   = ck_edge;
	assign seq_t.load   = enter_now || exit_now;
	assign seq_t.value  = enter_now ? SW'(CPDED_NCK) : SW'(XP_NCK);
	assign hold_t.load  = enter_now || exit_now;
	assign hold_t.value = SW'(CKE_NCK);
	assign dur_t.load   = enter_now;
	assign dur_t.value  = DW'(PD_MAX_NCK);

	// ****************************************************************
	// Power-down sequence.
	// ****************************************************************
	// Next state; the reset pin overrides everything, even mid power-down.
	always_comb begin
		next_state = state;
		case (state)
			pdc_pkg::PDC_RESET: begin
				if (rstn_s) begin
					next_state = pdc_pkg::PDC_IDLE;
				end
			end
			pdc_pkg::PDC_IDLE: begin
				if (enter_now) begin
					next_state = pdc_pkg::PDC_ENTRY;
				end
			end
			pdc_pkg::PDC_ENTRY: begin
				if (exit_now) begin
					next_state = pdc_pkg::PDC_EXIT;
				end else if (seq_t.done) begin
					next_state = pdc_pkg::PDC_DOWN;
				end
			end
			pdc_pkg::PDC_DOWN: begin
				if (exit_now) begin
					next_state = pdc_pkg::PDC_EXIT;
				end
			end
			pdc_pkg::PDC_EXIT: begin
				if (seq_t.done) begin
					next_state = pdc_pkg::PDC_IDLE;
				end
			end
			default: begin
				next_state = pdc_pkg::PDC_RESET;
			end
		endcase
		if (!rstn_s) begin
			next_state = pdc_pkg::PDC_RESET;
		end
	end

	// State register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= pdc_pkg::PDC_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Entry window history of ODT.
	// ****************************************************************
	logic [WLMAX-1:0] odt_hist;  // ODT samples, bit 0 the newest CK edge.
	logic             odt_win;   // ODT high anywhere in the window.

	// Shift one sample per CK edge so the window is counted in CK cycles.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			odt_hist <= '0;
		end else if (ck_edge) begin
			odt_hist <= {odt_hist[WLMAX-2:0], odt_s};
		end
	end

	// The window reaches back write latency less one edges before entry.
	always_comb begin
		odt_win = odt_s;
		for (int i = 0; i < WLMAX; i++) begin
			if ((WLW+1)'(i) + (WLW+1)'(2) <= {1'b0, write_lat}) begin
				odt_win = odt_win | odt_hist[i];
			end
		end
	end

	// Latched at entry; in buffer disable mode this marks that termination may resolve
	// to either nominal or park, so a user should not rely on which one.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			anpd_odt <= 1'b0;
		end else if (enter_now) begin
			anpd_odt <= odt_win;
		end else if (state == pdc_pkg::PDC_IDLE) begin
			anpd_odt <= 1'b0;
		end
	end

	// ****************************************************************
	// Buffer, termination and mode outputs.
	// ****************************************************************
	logic in_pd;     // Entered or down, CKE low registered.
	logic rx_off;    // Command receivers off.
	assign in_pd  = (state == pdc_pkg::PDC_ENTRY) || (state == pdc_pkg::PDC_DOWN);
	assign rx_off = (state == pdc_pkg::PDC_DOWN);

	// Outputs are registered; they follow the state one clk cycle later, which is far
	// inside one CK period, so the ports stay aligned to the CK edges.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_reset       <= 1'b1;
			pd_state       <= 1'b0;
			pd_precharge   <= 1'b0;
			pd_active      <= 1'b0;
			pd_low_current <= 1'b0;
			io_buf_en      <= 1'b0;
			cmd_rx_en      <= 1'b0;
			odt_buf_en     <= 1'b0;
			nom_term_en    <= 1'b0;
			park_term_en   <= 1'b0;
			dll_en         <= 1'b0;
			cmd_ready      <= 1'b0;
		end else begin
			in_reset       <= (state == pdc_pkg::PDC_RESET);
			pd_state       <= in_pd;
			// Mode is decided only once the core is quiet.
			pd_precharge   <= in_pd && !core_busy && !banks_open;
			pd_active      <= in_pd && !core_busy && banks_open;
			pd_low_current <= in_pd && !core_busy;
			io_buf_en      <= !in_pd && (state != pdc_pkg::PDC_RESET);
			cmd_rx_en      <= !rx_off && (state != pdc_pkg::PDC_RESET);
			// In disable mode ODT is still heeded until tCPDED has run out.
			odt_buf_en     <= (state != pdc_pkg::PDC_RESET) &&
			                  !(rx_off && odt_ibuf_off_mode);
			nom_term_en    <= nom_term_cfg && (state != pdc_pkg::PDC_RESET) &&
			                  !(in_pd && odt_ibuf_off_mode);
			park_term_en   <= in_pd && (park_sel != 3'h0);
			dll_en         <= (state != pdc_pkg::PDC_RESET);
			cmd_ready      <= (state == pdc_pkg::PDC_IDLE);
		end
	end

	// ****************************************************************
	// DLL reset request.
	// ****************************************************************
	// Set wins over the clear so an entry in the clearing cycle is not lost.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dll_reset_req <= 1'b0;
		end else if (state == pdc_pkg::PDC_RESET) begin
			dll_reset_req <= 1'b0;
		end else if (enter_now && !dll_locked) begin
			dll_reset_req <= 1'b1;
		end else if (dll_reset_done) begin
			dll_reset_req <= 1'b0;
		end
	end

	// ****************************************************************
	// Monitors of the controller's duties.
	// ****************************************************************
	// Sticky flags; only the device reset clears them, since the device cannot repair
	// a broken sequence and the flags serve as a record for debug.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			err_cke_forbidden <= 1'b0;
			err_cke_hold      <= 1'b0;
			err_pd_duration   <= 1'b0;
		end else if (state == pdc_pkg::PDC_RESET) begin
			err_cke_forbidden <= 1'b0;
			err_cke_hold      <= 1'b0;
			err_pd_duration   <= 1'b0;
		end else begin
			if (enter_now && locked_op_busy) begin
				err_cke_forbidden <= 1'b1;
			end
			// CKE back high too soon after entry, or low again too soon after exit.
			if ((exit_now && !hold_t.done) ||
			    (ck_edge && !cke_s && (state == pdc_pkg::PDC_EXIT) && !hold_t.done)) begin
				err_cke_hold <= 1'b1;
			end
			if (in_pd && dur_t.done) begin
				err_pd_duration <= 1'b1;
			end
		end
	end
endmodule // pdc_top
`default_nettype wire

// ---- tb/pdc_ctrl_model.sv ----
`default_nettype none
// ****************************************************************
// Memory controller side: link clock, clock enable, command, ODT.
// ****************************************************************
module pdc_ctrl_model (
	output logic      ck,       // Link clock, runs free.
	output logic      cke,      // Clock enable pin.
	output logic      cs_n,     // Chip select, high is deselect.
	output logic      odt,      // Termination control pin.
	input  wire logic cke_req,  // Wanted clock enable level.
	input  wire logic cs_req_n, // Wanted chip select level.
	input  wire logic odt_req,  // Wanted ODT level.
	input  wire logic odt_flt   // Let ODT float.
);
	timeunit 1ns;
	timeprecision 1ps;
	// The clock keeps running through power-down, offset in phase from clk.
	initial begin
		ck = 1'b0;
		cke = 1'b1;
		cs_n = 1'b1;
		odt = 1'b0;
		#3;
		forever #80 ck = ~ck;
	end
	// Pins move on the falling edge so the device samples them settled.
	// A floating ODT toggles every cycle, because an unknown would be settled arbitrarily.
	always @(negedge ck) begin
		cke <= cke_req;
		cs_n <= cs_req_n;
		odt <= odt_flt ? ~odt : odt_req;
	end
endmodule // pdc_ctrl_model
`default_nettype wire

// ---- tb/pdc_top_checker.sv ----
`default_nettype none
// ****************************************************************
// Port-level timing checks of the power-down control block.
// ****************************************************************
module pdc_top_checker (
	input wire logic       clk,               // System clock.
	input wire logic       rst,               // Reset, active high.
	input wire logic       reset_n_pin,       // Device reset pin.
	input wire logic       banks_open,        // Bank status.
	input wire logic       odt_ibuf_off_mode, // ODT buffer disable mode.
	input wire logic [2:0] park_sel,          // Park field.
	input wire logic       in_reset,          // Reset state.
	input wire logic       pd_state,          // Powered down.
	input wire logic       pd_precharge,      // Precharge mode.
	input wire logic       pd_active,         // Active mode.
	input wire logic       pd_low_current,    // Low current applies.
	input wire logic       io_buf_en,         // Buffers on.
	input wire logic       cmd_rx_en,         // Receivers on.
	input wire logic       odt_buf_en,        // ODT buffer on.
	input wire logic       nom_term_en,       // Nominal termination.
	input wire logic       park_term_en,      // Park termination.
	input wire logic       dll_en,            // DLL on.
	input wire logic       cmd_ready          // Commands allowed.
);
	default clocking chk_cb @(posedge clk); endclocking
	default disable iff (rst);
	// Depths below assume the bench link clock of eight clk cycles.
	sequence s_rst_low;
		!reset_n_pin [*4];
	endsequence
	sequence s_quiet;
		(!io_buf_en && cmd_rx_en) [*8];
	endsequence
	property p_reset_pin;
		s_rst_low |=> ##[0:3] (in_reset && !pd_state);
	endproperty
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin ignored");
	property p_entry;
		$rose(pd_state) |-> s_quiet;
	endproperty
	a_entry: assert property (p_entry) else $error("entry buffers wrong");
	property p_rx_late;
		$fell(cmd_rx_en) && !in_reset |-> $past(pd_state, 28);
	endproperty
	a_rx_late: assert property (p_rx_late) else $error("receivers off early");
	property p_exit_lat;
		$rose(cmd_ready) |-> !$past(pd_state, 60);
	endproperty
	a_exit_lat: assert property (p_exit_lat) else $error("exit latency short");
	property p_mode;
		pd_low_current |-> pd_active == $past(banks_open) && pd_precharge != pd_active;
	endproperty
	a_mode: assert property (p_mode) else $error("power-down mode wrong");
	property p_dll;
		!in_reset |-> dll_en;
	endproperty
	a_dll: assert property (p_dll) else $error("dll disabled");
	property p_park;
		pd_state && $past(pd_state) && $stable(park_sel) && park_sel != 3'h0 |-> park_term_en;
	endproperty
	a_park: assert property (p_park) else $error("park termination lost");
	property p_nom;
		pd_state && $past(pd_state) && odt_ibuf_off_mode && $past(odt_ibuf_off_mode)
			|-> !nom_term_en;
	endproperty
	a_nom: assert property (p_nom) else $error("nominal termination kept");
	property p_odt_on;
		!in_reset && !odt_ibuf_off_mode && !$past(odt_ibuf_off_mode) |-> odt_buf_en;
	endproperty
	a_odt_on: assert property (p_odt_on) else $error("odt buffer off");
endmodule // pdc_top_checker
bind pdc_top pdc_top_checker chk (.clk, .rst, .reset_n_pin, .banks_open, .odt_ibuf_off_mode,
	.park_sel, .in_reset, .pd_state, .pd_precharge, .pd_active, .pd_low_current, .io_buf_en,
	.cmd_rx_en, .odt_buf_en, .nom_term_en, .park_term_en, .dll_en, .cmd_ready);
`default_nettype wire

// ---- tb/pdc_top_bench.sv ----
`default_nettype none
// ****************************************************************
// Bench: stimulus notes expectations, a watcher compares on CK edges.
// ****************************************************************
module pdc_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {int at; int s; logic e;} pdc_note_t;
	logic        clk, rst, ck_pin, cke_pin, cs_n_pin, reset_n_pin, odt_pin, odt_flt;
	logic        banks_open, core_busy, locked_op_busy, dll_locked, dll_reset_done;
	logic        odt_ibuf_off_mode, nom_term_cfg, cke_req, cs_req_n, odt_req;
	logic [2:0]  park_sel;
	logic [5:0]  write_lat;
	logic        in_reset, pd_state, pd_precharge, pd_active, pd_low_current, io_buf_en;
	logic        cmd_rx_en, odt_buf_en, nom_term_en, park_term_en, dll_en, cmd_ready;
	logic        dll_reset_req, anpd_odt, err_cke_forbidden, err_cke_hold, err_pd_duration;
	logic [16:0] obs;          // All outputs, in_reset at bit 0.
	logic [31:0] rnd = 32'he42c; // Random source state.
	int          ne, E, error_cnt, checked; // Link edge count, entry edge, counters.
	pdc_note_t   q[$];         // Expected values in edge order.
	string       nm[17] = '{"in_reset", "pd_state", "pd_precharge", "pd_active",
		"pd_low_current", "io_buf_en", "cmd_rx_en", "odt_buf_en", "nom_term_en",
		"park_term_en", "dll_en", "cmd_ready", "dll_reset_req", "anpd_odt",
		"err_cke_forbidden", "err_cke_hold", "err_pd_duration"};
	assign obs = {err_pd_duration, err_cke_hold, err_cke_forbidden, anpd_odt, dll_reset_req,
		cmd_ready, dll_en, park_term_en, nom_term_en, odt_buf_en, cmd_rx_en, io_buf_en,
		pd_low_current, pd_active, pd_precharge, pd_state, in_reset};
	// A short duration limit keeps the run brief.
	pdc_top #(.PD_MAX_NCK(50)) dut (.clk, .rst, .ck_pin, .cke_pin, .cs_n_pin, .reset_n_pin,
		.odt_pin, .banks_open, .core_busy, .locked_op_busy, .dll_locked, .dll_reset_done,
		.odt_ibuf_off_mode, .park_sel, .nom_term_cfg, .write_lat, .in_reset, .pd_state,
		.pd_precharge, .pd_active, .pd_low_current, .io_buf_en, .cmd_rx_en, .odt_buf_en,
		.nom_term_en, .park_term_en, .dll_en, .cmd_ready, .dll_reset_req, .anpd_odt,
		.err_cke_forbidden, .err_cke_hold, .err_pd_duration);
	pdc_ctrl_model ctrl (.ck(ck_pin), .cke(cke_pin), .cs_n(cs_n_pin), .odt(odt_pin),
		.cke_req, .cs_req_n, .odt_req, .odt_flt);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Waits until link edge t has passed, then steps just after a clk edge.
	task automatic upto(input int t);
		do @(posedge clk); while (ne < t);
		#1;
	endtask
	task automatic ex(input int d, input int s, input logic e);
		q.push_back('{E + d, s, e});
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// One power-down cycle; bit 0 of i opens a bank, bit 1 turns ODT buffer off.
	task automatic pd(input int i);
		logic b, m, cb, dl;
		logic [2:0] ps;
		int k;
		b = i[0];
		m = i[1];
		cb = (i == 3);
		rnd = lfsr(rnd);
		dl = rnd[3];
		ps = (i == 0) ? 3'h0 : (rnd[2:0] | 3'h1);
		k = 3 + 2 * b; // An open bank puts the ODT pulse outside the entry window.
		{banks_open, odt_ibuf_off_mode, core_busy, park_sel} = {b, m, cb, ps};
		{dll_locked, dll_reset_done, odt_req} = {dl, 1'b0, !m};
		nom_term_cfg = rnd[4];
		upto(ne + 1);
		odt_req = 1'b0;
		upto(ne + k - 1);
		cke_req = 1'b0;
		E = ne + 1;
		ex(1, 1, 1'b1);
		ex(1, 5, 1'b0);
		ex(1, 6, 1'b1);
		ex(1, 4, !cb);
		ex(1, 3, b & !cb);
		ex(1, 2, !b & !cb);
		ex(1, 9, ps != 3'h0);
		ex(1, 10, 1'b1);
		ex(1, 8, nom_term_cfg && !m);
		ex(1, 12, !dl);
		ex(1, 13, (k < write_lat) && !m);
		ex(2, 4, 1'b1);
		ex(2, 3, b);
		ex(4, 6, 1'b1);
		ex(5, 6, 1'b0);
		ex(5, 7, !m);
		ex(7, 1, 1'b1);
		ex(8, 1, 1'b0);
		ex(8, 6, 1'b1);
		ex(8, 11, 1'b0);
		ex(15, 11, 1'b0);
		ex(16, 11, 1'b1);
		ex(16, 15, 1'b0);
		ex(16, 13, 1'b0);
		ex(16, 12, 1'b0);
		upto(E + 1);
		core_busy = 1'b0;
		upto(E + 4);
		odt_flt = m;
		upto(E + 5);
		odt_flt = 1'b0;
		upto(E + 6);
		{cke_req, cs_req_n} = 2'h3;
		upto(E + 15);
		dll_reset_done = 1'b1;
		upto(E + 16);
	endtask
	// Results are compared a moment after each link rising edge.
	initial begin
		pdc_note_t n;
		forever begin
			@(posedge ck_pin);
			ne++;
			#1;
			while (q.size() > 0 && q[0].at <= ne) begin
				n = q.pop_front();
				checked++;
				if (obs[n.s] !== n.e) begin
					error_cnt++;
					$display("mismatch %s expected %b seen %b", nm[n.s], n.e, obs[n.s]);
				end
			end
		end
	end
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// The run takes about 1300 clk cycles; far beyond that it is hung.
	initial begin
		#200us;
		error_cnt++;
		results();
	end
	initial begin
		{rst, reset_n_pin, cke_req, cs_req_n, odt_req, odt_flt, nom_term_cfg} = 7'h79;
		{banks_open, core_busy, locked_op_busy, dll_locked, dll_reset_done} = 5'h02;
		park_sel = 3'h0;
		write_lat = 6'h05;
		odt_req = 1'b0;
		odt_flt = 1'b0;
		repeat (5) @(posedge clk);
		#1 rst = 1'b0;
		upto(ne + 2);
		E = ne;
		ex(1, 0, 1'b0);
		ex(1, 10, 1'b1);
		ex(1, 11, 1'b1);
		for (int i = 0; i < 4; i++) pd(i);
		// Entry during a locked operation, then an exit inside the hold time.
		locked_op_busy = 1'b1;
		cke_req = 1'b0;
		E = ne + 1;
		ex(1, 14, 1'b1);
		ex(3, 15, 1'b1);
		ex(10, 15, 1'b1);
		upto(E + 1);
		{locked_op_busy, cke_req} = 2'h1;
		upto(E + 12);
		cke_req = 1'b0;
		E = ne + 1;
		ex(1, 1, 1'b1);
		ex(1, 14, 1'b1);
		ex(50, 16, 1'b0);
		ex(51, 16, 1'b1);
		upto(E + 52);
		{reset_n_pin, cke_req} = 2'h1;
		ex(54, 0, 1'b1);
		ex(54, 1, 1'b0);
		ex(54, 14, 1'b0);
		ex(54, 15, 1'b0);
		ex(54, 16, 1'b0);
		upto(E + 62);
		reset_n_pin = 1'b1;
		ex(64, 0, 1'b0);
		ex(64, 11, 1'b1);
		ex(64, 5, 1'b1);
		upto(E + 65);
		results();
	end
endmodule // pdc_top_bench
`default_nettype wire
